/* File: design/mcu_core_alu_ops.v */
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`include "alu_core_map.vh"

module mcu_core_alu_ops (
  // Clock and reset
  input wire CLK_I,
  input wire RST_B_I,
  // APB slave
  input wire PSEL_I,
  input wire PENABLE_I,
  input wire PWRITE_I,
  input wire [11:0] PADDR_I,
  input wire [31:0] PWDATA_I,
  output reg [31:0] PRDATA_O,
  output reg PREADY_O,
  output reg PSLVERR_O,
  // Core state
  output reg [7:0] ACC_O,
  output reg [14:0] PC_O,
  output reg BUSY_O
);

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  reg rst_meta_b;
  reg rst_b;

  // Reset asserts at once and releases after two edges.
  // Every other register except the file registers resets from the released copy, so none of them
  // leaves reset on an edge at which the pin itself may still be moving.
  always @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      rst_meta_b <= 1'b0;
      rst_b <= 1'b0;
    end else begin
      rst_meta_b <= 1'b1;
      rst_b <= rst_meta_b;
    end
  end

  // ----------------------------------------
  // Core state
  // ----------------------------------------
  // Status flags: carry, half carry and zero.
  reg flag_c;
  reg flag_dc;
  reg flag_z;
  // Indirect pointer pairs and the page latch for the branch.
  reg [15:0] ptr0;
  reg [15:0] ptr1;
  reg [6:0] page_latch;
  // Bookkeeping that software can read.
  reg [31:0] instr_count;
  reg [7:0] last_result;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  // An access phase is answered once; done marks the edge at which a transfer takes effect.
  wire access = PSEL_I && PENABLE_I;
  wire done = access && PREADY_O;
  // The file window holds one aligned word per file register.
  wire is_file = (PADDR_I >= `OFS_FILE_BASE) && (PADDR_I <= `OFS_FILE_LAST) && (PADDR_I[1:0] == 2'b00);
  wire [6:0] bus_faddr = PADDR_I[8:2];
  wire instr_wr = PWRITE_I && (PADDR_I == `OFS_INSTR);
  // A new instruction waits while the second slot of the previous one runs.
  wire stall = instr_wr && BUSY_O;
  wire exec = done && instr_wr;

  // Returns 1 when the byte address names a register outside the file window.
  function mapped;
    input [11:0] a;
    begin
      case (a)
        `OFS_INSTR, `OFS_ACC, `OFS_STATUS, `OFS_PTR0, `OFS_PTR1,
        `OFS_PAGE, `OFS_PC, `OFS_COUNT, `OFS_LAST: mapped = 1'b1;
        default: mapped = 1'b0;
      endcase
    end
  endfunction

  // ----------------------------------------
  // Instruction fields
  // ----------------------------------------
  // Fields come straight from the write data, so an instruction acts at the edge that completes its write.
  wire [3:0] op = PWDATA_I[`INSTR_OP];
  wire dest = PWDATA_I[`INSTR_DEST];
  wire psel_ptr = PWDATA_I[`INSTR_PSEL];
  wire [6:0] faddr = PWDATA_I[`INSTR_FADDR];
  wire [7:0] lit8 = PWDATA_I[`INSTR_LIT8];
  wire [10:0] lit11 = PWDATA_I[`INSTR_LIT11];
  wire [5:0] lit6 = PWDATA_I[`INSTR_LIT6];

  // ----------------------------------------
  // Datapath
  // ----------------------------------------
  // Operands and results of the arithmetic unit.
  wire [7:0] file_op_val;
  wire [7:0] file_bus_val;
  wire [7:0] alu_result;
  wire alu_c;
  wire alu_dc;
  wire alu_z;
  wire set_c;
  wire set_dc;
  wire set_z;
  wire alu_valid;
  wire alu_file_op;
  wire alu_skip;

  // The arithmetic unit works on the accumulator and either the literal or the addressed file register.
  alu_core u_alu (
    .op_i(op),
    .acc_i(ACC_O),
    .file_i(file_op_val),
    .lit_i(lit8),
    .carry_i(flag_c),
    .result_o(alu_result),
    .carry_o(alu_c),
    .half_o(alu_dc),
    .zero_o(alu_z),
    .set_c_o(set_c),
    .set_dc_o(set_dc),
    .set_z_o(set_z),
    .valid_o(alu_valid),
    .file_op_o(alu_file_op),
    .skip_o(alu_skip)
  );

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  // File write-back happens for an executed file operation with destination 1, or a bus write.
  // The two never meet in one cycle, because an instruction write does not name a file address.
  wire to_file = exec && alu_valid && alu_file_op && dest;
  wire bus_file_wr = done && PWRITE_I && is_file;
  wire mem_wr = to_file || bus_file_wr;
  wire [6:0] mem_waddr = to_file ? faddr : bus_faddr;
  wire [7:0] mem_wdata = to_file ? alu_result : PWDATA_I[7:0];

  // Port a serves the instruction operand, port b the bus read.
  file_mem #(
    .AW(7),
    .DW(8)
  ) u_file (
    .clk_i(CLK_I),
    .wr_en_i(mem_wr),
    .wr_addr_i(mem_waddr),
    .wr_data_i(mem_wdata),
    .rd_a_addr_i(faddr),
    .rd_a_data_o(file_op_val),
    .rd_b_addr_i(bus_faddr),
    .rd_b_data_o(file_bus_val)
  );

  // ----------------------------------------
  // Pointer arithmetic
  // ----------------------------------------
  // Pointer sum: sign-extend the literal and let the 16-bit add wrap.
  // A negative literal thus wraps below zero to the top of the pointer range.
  wire [15:0] ptr_sel = psel_ptr ? ptr1 : ptr0;
  wire [15:0] ptr_sum = ptr_sel + {{10{lit6[5]}}, lit6};

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  // Word that the next answer will carry.
  reg [31:0] rd_value;

  // Selects read data; bits above a register's width read as zero.
  always @* begin
    rd_value = 32'h00000000;
    if (is_file) begin
      rd_value = {24'h000000, file_bus_val};
    end else begin
      case (PADDR_I)
        `OFS_ACC: rd_value = {24'h000000, ACC_O};
        `OFS_STATUS: rd_value = {28'h0000000, BUSY_O, flag_z, flag_dc, flag_c};
        `OFS_PTR0: rd_value = {16'h0000, ptr0};
        `OFS_PTR1: rd_value = {16'h0000, ptr1};
        `OFS_PAGE: rd_value = {25'h0000000, page_latch};
        `OFS_PC: rd_value = {17'h00000, PC_O};
        `OFS_COUNT: rd_value = instr_count;
        `OFS_LAST: rd_value = {24'h000000, last_result};
        default: rd_value = 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------
  // APB answer
  // ----------------------------------------
  // Answers one cycle into the access phase; an instruction write also waits out a busy slot.
  // PREADY_O drops in the cycle after it stands, so every transfer sees one answer only.
  // Read data and error read zero outside the answer cycle.
  always @(posedge CLK_I or negedge rst_b) begin
    if (!rst_b) begin
      PREADY_O <= 1'b0;
      PSLVERR_O <= 1'b0;
      PRDATA_O <= 32'h00000000;
    end else begin
      PREADY_O <= access && !PREADY_O && !stall;
      if (access && !PREADY_O && !stall) begin
        PSLVERR_O <= !(mapped(PADDR_I) || is_file) || (PWRITE_I && (PADDR_I == `OFS_PC));
        PRDATA_O <= PWRITE_I ? 32'h00000000 : rd_value;
      end else begin
        PSLVERR_O <= 1'b0;
        PRDATA_O <= 32'h00000000;
      end
    end
  end

  // ----------------------------------------
  // Execution and software writes
  // ----------------------------------------
  // Each instruction commits at the edge that completes its bus write.
  always @(posedge CLK_I or negedge rst_b) begin
    if (!rst_b) begin
      ACC_O <= `ACC_RST;
      flag_c <= 1'b0;
      flag_dc <= 1'b0;
      flag_z <= 1'b0;
      ptr0 <= `PTR_RST;
      ptr1 <= `PTR_RST;
      page_latch <= `PAGE_RST;
      PC_O <= `PC_RST;
      BUSY_O <= 1'b0;
      instr_count <= 32'h00000000;
      last_result <= 8'h00;
    end else begin
      // The second slot lasts exactly one cycle.
      BUSY_O <= 1'b0;
      // An executed instruction owns this edge; the bus is busy with its word.
      if (exec) begin
        instr_count <= instr_count + 32'h00000001;
        // Flags change only where the operation asks; skip forms and pointer add keep them.
        if (alu_valid) begin
          last_result <= alu_result;
          if (!(alu_file_op && dest)) begin
            ACC_O <= alu_result;
          end
          if (set_c) begin
            flag_c <= alu_c;
          end
          if (set_dc) begin
            flag_dc <= alu_dc;
          end
          if (set_z) begin
            flag_z <= alu_z;
          end
        end
        // The pointer add touches no flag.
        if (op == `OP_POINTER_ADD) begin
          if (psel_ptr) begin
            ptr1 <= ptr_sum;
          end else begin
            ptr0 <= ptr_sum;
          end
        end
        // A branch or taken skip spends the next cycle in the no_operation slot.
        if (op == `OP_BRANCH) begin
          PC_O <= {page_latch[`PAGE_SRC], lit11};
          BUSY_O <= 1'b1;
        end else if (alu_skip) begin
          PC_O <= PC_O + 15'h0002;
          BUSY_O <= 1'b1;
        end else begin
          PC_O <= PC_O + 15'h0001;
        end
      end else if (done && PWRITE_I) begin
        // Software writes; the counter is read-only and a write to the count clears it.
        case (PADDR_I)
          `OFS_ACC: ACC_O <= PWDATA_I[7:0];
          `OFS_STATUS: begin
            flag_c <= PWDATA_I[`STAT_C];
            flag_dc <= PWDATA_I[`STAT_DC];
            flag_z <= PWDATA_I[`STAT_Z];
          end
          `OFS_PTR0: ptr0 <= PWDATA_I[15:0];
          `OFS_PTR1: ptr1 <= PWDATA_I[15:0];
          `OFS_PAGE: page_latch <= PWDATA_I[6:0];
          `OFS_COUNT: instr_count <= 32'h00000000;
          default: ACC_O <= ACC_O;
        endcase
      end
    end
  end

endmodule

/* File: design/alu_core_map.vh */
`ifndef ALU_CORE_MAP_VH
`define ALU_CORE_MAP_VH

// ----------------------------------------
// Register byte offsets on the APB bus
// ----------------------------------------
`define OFS_INSTR 12'h000
`define OFS_ACC 12'h004
`define OFS_STATUS 12'h008
`define OFS_PTR0 12'h00c
`define OFS_PTR1 12'h010
`define OFS_PAGE 12'h014
`define OFS_PC 12'h018
`define OFS_COUNT 12'h01c
`define OFS_LAST 12'h020
`define OFS_FILE_BASE 12'h200
`define OFS_FILE_LAST 12'h3fc

// ----------------------------------------
// Instruction word fields
// ----------------------------------------
`define INSTR_OP 3:0
`define INSTR_DEST 4
`define INSTR_PSEL 5
`define INSTR_FADDR 14:8
`define INSTR_LIT11 26:16
`define INSTR_LIT8 23:16
`define INSTR_LIT6 21:16

// ----------------------------------------
// Operation codes
// ----------------------------------------
`define OP_POINTER_ADD 4'h0
`define OP_AND_LIT 4'h1
`define OP_ADD_LIT 4'h2
`define OP_AND_FILE 4'h3
`define OP_ADD_FILE 4'h4
`define OP_ASR_FILE 4'h5
`define OP_ADDC_FILE 4'h6
`define OP_DEC_SKIP 4'h7
`define OP_BRANCH 4'h8
`define OP_INC_SKIP 4'h9
`define OP_OR_LIT 4'ha
`define OP_INC_FILE 4'hb
`define OP_OR_FILE 4'hc

// ----------------------------------------
// Status bits, page source and reset values
// ----------------------------------------
`define STAT_C 0
`define STAT_DC 1
`define STAT_Z 2
`define STAT_BUSY 3
`define PAGE_SRC 6:3
`define ACC_RST 8'h00
`define PTR_RST 16'h0000
`define PAGE_RST 7'h00
`define PC_RST 15'h0000

`endif

/* File: design/file_mem.v */
`timescale 1ns/1ps
`include "alu_core_map.vh"

// ----------------------------------------
// Data register file with one write port and two read ports
// ----------------------------------------
module file_mem #(
  parameter AW = 7,
  parameter DW = 8
) (
  // Clock
  input wire clk_i,
  // Write port
  input wire wr_en_i,
  input wire [AW-1:0] wr_addr_i,
  input wire [DW-1:0] wr_data_i,
  // Read ports
  input wire [AW-1:0] rd_a_addr_i,
  output wire [DW-1:0] rd_a_data_o,
  input wire [AW-1:0] rd_b_addr_i,
  output wire [DW-1:0] rd_b_data_o
);

  reg [DW-1:0] mem [0:(1<<AW)-1];

  // Write commits at the clock edge.
  always @(posedge clk_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end

  // Reads are combinational so the datapath sees the operand in the same cycle.
  assign rd_a_data_o = mem[rd_a_addr_i];
  assign rd_b_data_o = mem[rd_b_addr_i];

endmodule

/* File: design/alu_core.v */
`timescale 1ns/1ps
`include "alu_core_map.vh"

// ----------------------------------------
// Combinational arithmetic and logic unit
// ----------------------------------------
module alu_core (
  // Operation and operands
  input wire [3:0] op_i,
  input wire [7:0] acc_i,
  input wire [7:0] file_i,
  input wire [7:0] lit_i,
  input wire carry_i,
  // Result and flags
  output reg [7:0] result_o,
  output reg carry_o,
  output reg half_o,
  output wire zero_o,
  // Which flags and which destination the result updates
  output reg set_c_o,
  output reg set_dc_o,
  output reg set_z_o,
  output reg valid_o,
  output reg file_op_o,
  output wire skip_o
);

  reg [9:0] sum;

  // Returns {half carry, carry, sum} of a + b + cin.
  function [9:0] add_flags;
    input [7:0] a;
    input [7:0] b;
    input cin;
    reg [4:0] lo;
    reg [8:0] full;
    begin
      lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
      full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
      add_flags = {lo[4], full};
    end
  endfunction

  // Result selection and flag masks per operation.
  always @* begin
    sum = 10'h000;
    result_o = 8'h00;
    carry_o = 1'b0;
    half_o = 1'b0;
    set_c_o = 1'b0;
    set_dc_o = 1'b0;
    set_z_o = 1'b0;
    valid_o = 1'b1;
    file_op_o = 1'b1;
    case (op_i)
      `OP_AND_LIT: begin
        result_o = acc_i & lit_i;
        set_z_o = 1'b1;
        file_op_o = 1'b0;
      end
      `OP_OR_LIT: begin
        result_o = acc_i | lit_i;
        set_z_o = 1'b1;
        file_op_o = 1'b0;
      end
      `OP_ADD_LIT: begin
        sum = add_flags(acc_i, lit_i, 1'b0);
        file_op_o = 1'b0;
      end
      `OP_ADD_FILE: begin
        sum = add_flags(acc_i, file_i, 1'b0);
      end
      `OP_ADDC_FILE: begin
        sum = add_flags(acc_i, file_i, carry_i);
      end
      `OP_AND_FILE: begin
        result_o = acc_i & file_i;
        set_z_o = 1'b1;
      end
      `OP_OR_FILE: begin
        result_o = acc_i | file_i;
        set_z_o = 1'b1;
      end
      `OP_ASR_FILE: begin
        result_o = {file_i[7], file_i[7:1]};
        carry_o = file_i[0];
        set_c_o = 1'b1;
        set_z_o = 1'b1;
      end
      `OP_DEC_SKIP: begin
        result_o = file_i - 8'h01;
      end
      `OP_INC_SKIP: begin
        result_o = file_i + 8'h01;
      end
      `OP_INC_FILE: begin
        result_o = file_i + 8'h01;
        set_z_o = 1'b1;
      end
      default: begin
        valid_o = 1'b0;
        file_op_o = 1'b0;
      end
    endcase
    // The three add forms share the flag outputs of the adder.
    if (op_i == `OP_ADD_LIT || op_i == `OP_ADD_FILE || op_i == `OP_ADDC_FILE) begin
      result_o = sum[7:0];
      carry_o = sum[8];
      half_o = sum[9];
      set_c_o = 1'b1;
      set_dc_o = 1'b1;
      set_z_o = 1'b1;
    end
  end

  assign zero_o = (result_o == 8'h00);
  // A zero result from the skip forms turns the next slot into a no_operation.
  assign skip_o = zero_o && (op_i == `OP_DEC_SKIP || op_i == `OP_INC_SKIP);

endmodule

/* File: test/mcu_core_alu_ops_chk.sv */
`timescale 1ns/1ps
`include "alu_core_map.vh"

// ----------------------------------------
// Port checker
// ----------------------------------------
module mcu_core_alu_ops_chk (
  // Clock and reset
  input wire CLK_I,
  input wire RST_B_I,
  // APB slave
  input wire PSEL_I,
  input wire PENABLE_I,
  input wire PWRITE_I,
  input wire [11:0] PADDR_I,
  input wire [31:0] PWDATA_I,
  input wire [31:0] PRDATA_O,
  input wire PREADY_O,
  input wire PSLVERR_O,
  // Core state
  input wire [7:0] ACC_O,
  input wire [14:0] PC_O,
  input wire BUSY_O
);
  // Opcode field of the word on the write bus.
  wire [3:0] op = PWDATA_I[3:0];
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RST_B_I);
  // An instruction word is taken at this edge.
  sequence s_exec;
    PREADY_O && PSEL_I && PENABLE_I && PWRITE_I && PADDR_I == `OFS_INSTR;
  endsequence
  // The no_operation slot lasts exactly one cycle.
  sequence s_slot;
    BUSY_O ##1 !BUSY_O;
  endsequence
  chk_ready_pulse: assert property (PREADY_O |=> !PREADY_O) else $error("ready longer than one cycle");
  chk_wait_state: assert property ($rose(PENABLE_I) && PSEL_I |-> !PREADY_O ##[1:2] PREADY_O)
    else $error("access answer out of time");
  chk_err_ready: assert property (PSLVERR_O |-> PREADY_O) else $error("error without ready");
  chk_rdata_idle: assert property (!PREADY_O |-> PRDATA_O == 32'h0) else $error("read data outside answer");
  chk_pc_readonly: assert property (PREADY_O && PWRITE_I && PADDR_I == `OFS_PC |-> PSLVERR_O)
    else $error("counter write not refused");
  chk_and_literal: assert property (s_exec ##0 op == `OP_AND_LIT |=>
    ACC_O == ($past(ACC_O) & $past(PWDATA_I[23:16]))) else $error("literal and wrong");
  chk_or_literal: assert property (s_exec ##0 op == `OP_OR_LIT |=>
    ACC_O == ($past(ACC_O) | $past(PWDATA_I[23:16]))) else $error("literal or wrong");
  chk_add_literal: assert property (s_exec ##0 op == `OP_ADD_LIT |=>
    ACC_O == $past(ACC_O) + $past(PWDATA_I[23:16])) else $error("literal add wrong");
  chk_branch_target: assert property (s_exec ##0 op == `OP_BRANCH |=>
    PC_O[10:0] == $past(PWDATA_I[26:16]) ##0 s_slot) else $error("branch target wrong");
  chk_single_cycle: assert property (s_exec ##0 (op < 4'h7 || op > 4'h9) |=>
    !BUSY_O && PC_O == $past(PC_O) + 15'h1) else $error("plain step wrong");
  chk_busy_cause: assert property ($rose(BUSY_O) |-> $past(PREADY_O && PWRITE_I))
    else $error("slot without instruction");
endmodule

bind mcu_core_alu_ops mcu_core_alu_ops_chk u_chk (.CLK_I(CLK_I), .RST_B_I(RST_B_I), .PSEL_I(PSEL_I),
  .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O),
  .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .ACC_O(ACC_O), .PC_O(PC_O), .BUSY_O(BUSY_O));

/* File: test/mcu_core_alu_ops_tb_top.sv */
`timescale 1ns/1ps
`include "alu_core_map.vh"
`define CHK(g, w) begin tests_run = tests_run + 1; if ((g) !== (w)) begin num_errors = num_errors + 1; \
  $display("BAD %0t got %h want %h", $time, (g), (w)); end end

module mcu_core_alu_ops_tb_top;
  reg clk = 1'b0;
  reg rst_b = 1'b0;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0;
  wire [31:0] prdata;
  wire pready;
  wire pslverr;
  wire [7:0] acc;
  wire [14:0] pc;
  wire busy;
  integer num_errors = 0;
  integer tests_run = 0;
  integer i;
  reg [31:0] rd;
  reg err;
  reg [7:0] e_acc = 8'h00;
  reg e_c = 1'b0;
  reg e_dc = 1'b0;
  reg e_z = 1'b0;
  reg [14:0] e_pc = 15'h0;
  reg [15:0] e_ptr [0:1];
  reg [7:0] e_f [0:127];
  reg [6:0] e_page = 7'h58;
  reg [7:0] e_last = 8'h00;
  integer n_run = 0;
  // Clock of 100 MHz.
  always #5 clk = ~clk;
  mcu_core_alu_ops u_mcu_core_alu_ops (.CLK_I(clk), .RST_B_I(rst_b), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .ACC_O(acc), .PC_O(pc), .BUSY_O(busy));
  // Prints the counts and the verdict, then stops.
  task wrap_up;
    begin
      $display("errors %0d checks %0d", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0) begin
        $display("TEST PASSED");
      end else begin
        $display("TEST FAILED");
      end
      $finish;
    end
  endtask
  // One APB transfer; read data and error land in rd and err.
  task apb(input w, input [11:0] a, input [31:0] wd);
    integer n;
    begin
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
        @(posedge clk);
        n = n + 1;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
        num_errors = num_errors + 1;
        $display("BAD %0t no ready", $time);
        wrap_up;
      end
    end
  endtask
  // Loads one file register and its expected copy.
  task setf(input [6:0] f, input [7:0] v);
    begin
      apb(1'b1, `OFS_FILE_BASE + {f, 2'b00}, {24'h0, v});
      e_f[f] = v;
    end
  endtask
  // Executes one instruction against the reference and compares the state.
  task run(input [3:0] op, input d, input p, input [6:0] f, input [10:0] k);
    reg [7:0] b;
    reg [7:0] r;
    reg [8:0] s;
    reg [4:0] h;
    reg sk;
    begin
      b = (op == 4'h1 || op == 4'h2 || op == 4'ha) ? k[7:0] : e_f[f];
      s = e_acc + b + (op == 4'h6 ? e_c : 1'b0);
      h = e_acc[3:0] + b[3:0] + (op == 4'h6 ? e_c : 1'b0);
      case (op)
        4'h1, 4'h3: r = e_acc & b;
        4'ha, 4'hc: r = e_acc | b;
        4'h2, 4'h4, 4'h6: r = s[7:0];
        4'h5: r = {b[7], b[7:1]};
        4'h7: r = b - 8'h01;
        default: r = b + 8'h01;
      endcase
      sk = op == 4'h8 || ((op == 4'h7 || op == 4'h9) && r == 8'h00);
      if (op == 4'h2 || op == 4'h4 || op == 4'h6) begin
        e_c = s[8];
        e_dc = h[4];
      end
      if (op == 4'h5) e_c = b[0];
      if ((op >= 4'h1 && op <= 4'h6) || (op >= 4'ha && op <= 4'hc)) e_z = r == 8'h00;
      if (op == 4'h1 || op == 4'h2 || op == 4'ha) e_acc = r;
      else if (op >= 4'h3 && op <= 4'hc && op != 4'h8 && !d) e_acc = r;
      else if (op >= 4'h3 && op <= 4'hc && op != 4'h8) e_f[f] = r;
      if (op == 4'h0) e_ptr[p] = e_ptr[p] + {{10{k[5]}}, k[5:0]};
      if (op != 4'h0 && op != 4'h8 && op <= 4'hc) e_last = r;
      n_run = n_run + 1;
      e_pc = op == 4'h8 ? {e_page[6:3], k} : e_pc + (sk ? 15'h2 : 15'h1);
      apb(1'b1, `OFS_INSTR, {5'h00, k, 1'b0, f, 2'b00, p, d, op});
      #1;
      `CHK(busy, sk)
      `CHK(acc, e_acc)
      apb(1'b0, `OFS_STATUS, 32'h0);
      `CHK(rd[2:0], {e_z, e_dc, e_c})
      apb(1'b0, `OFS_FILE_BASE + {f, 2'b00}, 32'h0);
      `CHK(rd[7:0], e_f[f])
      apb(1'b0, p ? `OFS_PTR1 : `OFS_PTR0, 32'h0);
      `CHK(rd[15:0], e_ptr[p])
      `CHK(pc, e_pc)
    end
  endtask
  // Main sequence: reset, state set-up, the instruction list, then bus refusals.
  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    for (i = 4; i <= 32'h18; i = i + 4) begin
      apb(1'b0, i[11:0], 32'h0);
      `CHK(rd, 32'h0)
    end
    apb(1'b1, `OFS_ACC, 32'hf0);
    e_acc = 8'hf0;
    apb(1'b1, `OFS_PTR0, 32'h0010);
    e_ptr[0] = 16'h0010;
    apb(1'b1, `OFS_PTR1, 32'hfffe);
    e_ptr[1] = 16'hfffe;
    apb(1'b1, `OFS_PAGE, {25'h0000000, e_page});
    setf(7'd0, 8'h01);
    setf(7'd2, 8'hff);
    setf(7'd5, 8'h80);
    setf(7'd127, 8'h0f);
    run(4'h1, 1'b0, 1'b0, 7'd0, 11'h00f);
    run(4'ha, 1'b0, 1'b0, 7'd0, 11'h0a5);
    run(4'h2, 1'b0, 1'b0, 7'd0, 11'h05b);
    run(4'h6, 1'b1, 1'b0, 7'd127, 11'h0);
    run(4'h4, 1'b0, 1'b0, 7'd5, 11'h0);
    run(4'h3, 1'b1, 1'b0, 7'd5, 11'h0);
    run(4'hc, 1'b0, 1'b0, 7'd127, 11'h0);
    run(4'h5, 1'b1, 1'b0, 7'd5, 11'h0);
    run(4'h5, 1'b0, 1'b0, 7'd0, 11'h0);
    run(4'h7, 1'b1, 1'b0, 7'd0, 11'h0);
    run(4'h7, 1'b0, 1'b0, 7'd5, 11'h0);
    run(4'h9, 1'b1, 1'b0, 7'd2, 11'h0);
    run(4'h9, 1'b0, 1'b0, 7'd5, 11'h0);
    run(4'hb, 1'b1, 1'b0, 7'd2, 11'h0);
    run(4'h0, 1'b0, 1'b0, 7'd0, 11'h01f);
    run(4'h0, 1'b0, 1'b0, 7'd0, 11'h020);
    run(4'h0, 1'b0, 1'b1, 7'd0, 11'h005);
    run(4'h0, 1'b0, 1'b1, 7'd0, 11'h03c);
    run(4'h8, 1'b0, 1'b0, 7'd0, 11'h7ff);
    run(4'h8, 1'b0, 1'b0, 7'd0, 11'h000);
    run(4'hd, 1'b0, 1'b0, 7'd0, 11'h0);
    apb(1'b1, `OFS_PC, 32'h1234);
    `CHK(err, 1'b1)
    apb(1'b0, `OFS_PC, 32'h0);
    `CHK(rd[14:0], e_pc)
    apb(1'b1, 12'h100, 32'hff);
    `CHK(err, 1'b1)
    apb(1'b0, 12'h100, 32'h0);
    `CHK(rd, 32'h0)
    apb(1'b0, `OFS_COUNT, 32'h0);
    `CHK(rd, n_run)
    apb(1'b0, `OFS_LAST, 32'h0);
    `CHK(rd[7:0], e_last)
    apb(1'b1, `OFS_COUNT, 32'h0);
    apb(1'b0, `OFS_COUNT, 32'h0);
    `CHK(rd, 32'h0)
    wrap_up;
  end
endmodule
